// file: hdl/dckd_decoder.sv
/*
 command and clock-enable decoder of a ddr3-class sdram: power states, row
 bookkeeping, read decode and zq calibration sequencing.
 assumes command pins synchronous to i_clock; i_reset_n is the device reset pin.
*/
//----------------------------------------------------------------
// What this block does
// [RULE1] action picked from previous and present cke; both low keeps low-power state
// [RULE2] low then high cke leaves low power; controller gives des or nop
// [RULE3] cke fall with des/nop enters active or precharge power-down by state
// [RULE4] cke fall with refresh while idle enters self refresh
// [RULE5] controller holds cke steady for its minimum registrations
// [RULE6] controller never applies unlisted state, cke and command combinations
// [RULE7] odt input has no effect on power-state decisions
// [RULE8] chip select high accepts no command; running work continues
// [RULE9] nop registers nothing and does not disturb running work
// [RULE10] long zq starts calibration, then loads drive and termination values
// [RULE11] controller waits init or operational calibration time after long zq
// [RULE12] controller may issue long zq at any time; one arriving while a calibration runs is ignored
// [RULE13] short zq corrects within 64 clocks; controller respects the window
// [RULE14] activate opens the addressed row in the addressed bank
// [RULE15] row stays open until a precharge addresses its bank
// [RULE16] controller precharges before activating another row in a bank
// [RULE17] read takes starting column from low three address bits
// [RULE18] address bit 10 high on read precharges the row after the burst
// [RULE19] with on-the-fly enabled, bit 12 low chops to 4, high gives 8
// [RULE20] accepted read burst runs to completion uninterrupted
// [RULE21] read is cke high twice, cs low, ras high, cas low, we high
// [RULE22] reset pin acts asynchronously only; held high in normal operation
// [RULE23] self refresh exit is recognised without clock edges
// [RULE24] no refresh is performed while in power-down
// [RULE25] per-bank open state and burst flag classify the current state
//----------------------------------------------------------------
`timescale 1ns/100ps
`include "dckd_consts.svh"

module dckd_decoder #(
    parameter int BANKS = `DCKD_BANKS,
    parameter int ZQINIT_CYC = `DCKD_ZQINIT_CYC,
    parameter int ZQOPER_CYC = `DCKD_ZQOPER_CYC
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_reset_n,
    input wire dckd_pkg::dckd_cmd_type i_cmd,
    input wire logic i_odt,
    input wire logic i_otf_en,
    input wire logic i_bc4_fixed,
    input wire logic [`DCKD_BA_W-1:0] i_row_bank,
    output logic [`DCKD_ROW_W-1:0] o_row,
    output logic [BANKS-1:0] o_bank_open,
    output logic o_burst_busy,
    output dckd_pkg::dckd_read_type o_read,
    output logic o_power_down,
    output logic o_active_pd,
    output logic o_self_refresh,
    output logic o_refresh_pulse,
    output logic o_zq_busy,
    output logic o_zq_load,
    output logic o_init_done
);
    //----------------------------------------------------------------
    // command decode
    //----------------------------------------------------------------
    // odt is deliberately unused here: it never steers power state  [RULE7]
    function automatic dckd_pkg::dckd_op_type decode(input dckd_pkg::dckd_cmd_type c);
        dckd_pkg::dckd_op_type op;
        op = dckd_pkg::DCKD_C_DES;
        if (!c.cs_n) begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'h0: op = dckd_pkg::DCKD_C_MRS;
                3'h1: op = dckd_pkg::DCKD_C_REF;
                3'h2: op = dckd_pkg::DCKD_C_PRE;
                3'h3: op = dckd_pkg::DCKD_C_ACT;
                3'h4: op = dckd_pkg::DCKD_C_WR;
                3'h5: op = dckd_pkg::DCKD_C_RD; // [RULE21]
                3'h6: op = c.addr[`DCKD_A_AP] ? dckd_pkg::DCKD_C_ZQCL
                                              : dckd_pkg::DCKD_C_ZQCS;
                default: op = dckd_pkg::DCKD_C_NOP; // [RULE9]
            endcase
        end
        return op;
    endfunction : decode

    function automatic logic is_idle_cmd(input dckd_pkg::dckd_op_type op);
        return (op == dckd_pkg::DCKD_C_DES) || (op == dckd_pkg::DCKD_C_NOP);
    endfunction : is_idle_cmd

    dckd_pkg::dckd_op_type op;
    logic cke_prev_reg;
    logic run;
    logic fall;
    logic rise;
    dckd_pkg::dckd_pwr_type pwr_reg;
    logic [BANKS-1:0] open_reg;
    logic [2:0] burst_cnt_reg;
    logic ap_pend_reg;
    logic [`DCKD_BA_W-1:0] ap_bank_reg;
    logic [1:0] pre_cnt_reg;
    logic ref_busy_reg;
    logic [15:0] zq_cnt_reg;
    logic sref_async_reg;
    logic sref_clear;

    always_comb begin
        op = decode(i_cmd);
    end

    assign run = cke_prev_reg && i_cmd.cke; // commands only with cke high twice  [RULE1]
    assign fall = cke_prev_reg && !i_cmd.cke;
    assign rise = !cke_prev_reg && i_cmd.cke;

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            // starts low so the first high sample after reset reads as an exit, not a command
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= i_cmd.cke; // [RULE1]
        end
    end

    //----------------------------------------------------------------
    // self refresh exit seen without a clock edge
    //----------------------------------------------------------------
    // cke rising sets this flag asynchronously; the clocked side clears it once
    // the exit has been taken, so a stopped clock cannot hide the exit
    // the clear is a registered one-cycle pulse, so it cannot glitch the flag
    always_ff @(posedge i_cmd.cke or negedge i_reset_n or posedge sref_clear) begin
        if (!i_reset_n || sref_clear) begin
            sref_async_reg <= 1'b0; // [RULE22]
        end else begin
            sref_async_reg <= 1'b1; // [RULE23]
        end
    end

    //----------------------------------------------------------------
    // state just before the edge, for the clock-enable decisions
    //----------------------------------------------------------------
    // registered state only, so a command on this edge cannot reclassify itself
    logic banks_busy;
    logic dev_idle;
    assign banks_busy = |open_reg || o_burst_busy
                        || pre_cnt_reg != 2'h0 || ap_pend_reg; // [RULE25]
    // a refresh still running means precharge power-down, but never idle
    assign dev_idle = !banks_busy && !ref_busy_reg && !o_zq_busy; // [RULE4]

    //----------------------------------------------------------------
    // power state
    //----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pwr_reg <= dckd_pkg::DCKD_S_RUN;
            sref_clear <= 1'b0;
        end else begin
            sref_clear <= 1'b0;
            case (pwr_reg)
                dckd_pkg::DCKD_S_RUN: begin
                    if (fall && is_idle_cmd(op)) begin // [RULE3]
                        // judged on state before this edge
                        if (banks_busy) begin
                            pwr_reg <= dckd_pkg::DCKD_S_APD;
                        end else begin
                            pwr_reg <= dckd_pkg::DCKD_S_PPD;
                        end
                    end else if (fall && op == dckd_pkg::DCKD_C_REF && dev_idle) begin
                        pwr_reg <= dckd_pkg::DCKD_S_SREF; // [RULE4]
                    end
                end
                dckd_pkg::DCKD_S_APD,
                dckd_pkg::DCKD_S_PPD: begin
                    // other commands on the exit edge are not executed
                    if (rise) begin
                        pwr_reg <= dckd_pkg::DCKD_S_RUN; // [RULE2]
                    end
                end
                dckd_pkg::DCKD_S_SREF: begin
                    if (rise || (sref_async_reg && i_cmd.cke)) begin
                        pwr_reg <= dckd_pkg::DCKD_S_RUN; // [RULE23]
                        sref_clear <= 1'b1;
                    end
                end
                default: pwr_reg <= dckd_pkg::DCKD_S_RUN;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_power_down <= 1'b0;
            o_active_pd <= 1'b0;
            o_self_refresh <= 1'b0;
        end else begin
            o_power_down <= (pwr_reg == dckd_pkg::DCKD_S_APD) || (pwr_reg == dckd_pkg::DCKD_S_PPD);
            o_active_pd <= pwr_reg == dckd_pkg::DCKD_S_APD;
            o_self_refresh <= pwr_reg == dckd_pkg::DCKD_S_SREF;
        end
    end

    //----------------------------------------------------------------
    // bank bookkeeping
    //----------------------------------------------------------------
    logic row_we;
    assign row_we = run && op == dckd_pkg::DCKD_C_ACT;

    dckd_row_mem #(
        .DEPTH(BANKS),
        .WIDTH(`DCKD_ROW_W)
    ) u_rows (
        .i_clock(i_clock),
        .i_we(row_we), // [RULE14]
        .i_waddr(i_cmd.ba),
        .i_wdata(i_cmd.addr[`DCKD_ROW_W-1:0]),
        .i_raddr(i_row_bank),
        .o_rdata(o_row)
    );

    // address bit 10 on precharge closes every bank at once
    genvar gb;
    generate
        for (gb = 0; gb < BANKS; gb++) begin : g_bank
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    open_reg[gb] <= 1'b0;
                end else if (run && op == dckd_pkg::DCKD_C_ACT && i_cmd.ba == gb) begin
                    open_reg[gb] <= 1'b1; // [RULE14] [RULE25]
                end else if (run && op == dckd_pkg::DCKD_C_PRE
                             && (i_cmd.addr[`DCKD_A_AP] || i_cmd.ba == gb)) begin
                    open_reg[gb] <= 1'b0; // [RULE15]
                end else if (ap_pend_reg && burst_cnt_reg == 3'h0 && ap_bank_reg == gb) begin
                    open_reg[gb] <= 1'b0; // [RULE18]
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_bank_open <= '0;
        end else begin
            o_bank_open <= open_reg;
        end
    end

    //----------------------------------------------------------------
    // read decode and burst tracking
    //----------------------------------------------------------------
    logic rd_take;
    logic rd_chop;
    // a read refused for a running burst is dropped, not queued
    assign rd_take = run && op == dckd_pkg::DCKD_C_RD && burst_cnt_reg == 3'h0;
    assign rd_chop = i_otf_en ? !i_cmd.addr[`DCKD_A_BC] : i_bc4_fixed; // [RULE19]

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            burst_cnt_reg <= 3'h0;
            ap_pend_reg <= 1'b0;
            ap_bank_reg <= '0;
        end else begin
            if (rd_take) begin
                // a running burst is never cut: new reads are taken only at zero  [RULE20]
                burst_cnt_reg <= rd_chop ? 3'(`DCKD_BURST_BC4) : 3'(`DCKD_BURST_BL8);
                ap_pend_reg <= i_cmd.addr[`DCKD_A_AP]; // [RULE18]
                ap_bank_reg <= i_cmd.ba;
            end else begin
                if (burst_cnt_reg != 3'h0) begin
                    burst_cnt_reg <= burst_cnt_reg - 3'h1; // [RULE20]
                end else begin
                    ap_pend_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_read <= '0;
            o_burst_busy <= 1'b0;
        end else begin
            o_read.valid <= rd_take; // [RULE21]
            // fields hold the last accepted read, so the data path never sees other commands
            if (rd_take) begin
                o_read.bank <= i_cmd.ba;
                o_read.col <= i_cmd.addr;
                o_read.start <= i_cmd.addr[`DCKD_COL_LO_W-1:0]; // [RULE17]
                o_read.auto_pre <= i_cmd.addr[`DCKD_A_AP];
                o_read.chop <= rd_chop; // [RULE19]
            end
            o_burst_busy <= rd_take || burst_cnt_reg > 3'h1; // [RULE25]
        end
    end

    //----------------------------------------------------------------
    // precharge and refresh activity
    //----------------------------------------------------------------
    // tracked only to classify power-down and self refresh entry, not to time the array
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pre_cnt_reg <= 2'h0;
            ref_busy_reg <= 1'b0;
            o_refresh_pulse <= 1'b0;
        end else begin
            if (run && op == dckd_pkg::DCKD_C_PRE) begin
                pre_cnt_reg <= 2'(`DCKD_PRE_CYC);
            end else if (pre_cnt_reg != 2'h0) begin
                pre_cnt_reg <= pre_cnt_reg - 2'h1;
            end
            // refresh only on a clocked command; none in power-down  [RULE24]
            o_refresh_pulse <= run && op == dckd_pkg::DCKD_C_REF;
            ref_busy_reg <= run && op == dckd_pkg::DCKD_C_REF;
        end
    end

    //----------------------------------------------------------------
    // zq calibration engine
    //----------------------------------------------------------------
    // des and nop fall through every branch here and leave the engine alone  [RULE8] [RULE9]
    // a calibration in progress is never restarted by a second command
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            zq_cnt_reg <= 16'h0;
            o_zq_busy <= 1'b0;
            o_zq_load <= 1'b0;
            o_init_done <= 1'b0;
        end else begin
            o_zq_load <= 1'b0;
            if (run && !o_zq_busy && op == dckd_pkg::DCKD_C_ZQCL) begin
                zq_cnt_reg <= o_init_done ? 16'(ZQOPER_CYC) : 16'(ZQINIT_CYC); // [RULE10]
                o_zq_busy <= 1'b1;
            end else if (run && !o_zq_busy && op == dckd_pkg::DCKD_C_ZQCS) begin
                zq_cnt_reg <= 16'(`DCKD_ZQCS_CYC); // [RULE13]
                o_zq_busy <= 1'b1;
            end else if (o_zq_busy) begin
                if (zq_cnt_reg == 16'h1) begin
                    o_zq_busy <= 1'b0;
                    o_zq_load <= 1'b1; // [RULE10]
                    o_init_done <= 1'b1;
                end
                zq_cnt_reg <= zq_cnt_reg - 16'h1;
            end
        end
    end

endmodule : dckd_decoder

// file: hdl/dckd_consts.svh
/*
 constants of the command and clock-enable decoder: field positions, widths, counts.
 assumes inclusion by the package and the design modules by bare name.
*/
`ifndef DCKD_CONSTS_SVH
`define DCKD_CONSTS_SVH

`define DCKD_BANKS 8
`define DCKD_BA_W 3
`define DCKD_ADDR_W 15
`define DCKD_ROW_W 15
`define DCKD_A_AP 10
`define DCKD_A_BC 12
`define DCKD_COL_LO_W 3
`define DCKD_BURST_BL8 4
`define DCKD_BURST_BC4 2
`define DCKD_CLK_NS 20
`define DCKD_ZQCS_CYC 64
`define DCKD_ZQINIT_CYC 512
`define DCKD_ZQOPER_CYC 256
`define DCKD_PRE_CYC 2

`endif

// file: hdl/dckd_pkg.sv
/*
 types of the command and clock-enable decoder.
 assumes dckd_consts.svh is on the include path.
*/
`include "dckd_consts.svh"

package dckd_pkg;

    // command pins as sampled on one rising clock edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [`DCKD_BA_W-1:0] ba;
        logic [`DCKD_ADDR_W-1:0] addr;
    } dckd_cmd_type;

    typedef enum logic [3:0] {
        DCKD_C_DES,
        DCKD_C_NOP,
        DCKD_C_MRS,
        DCKD_C_REF,
        DCKD_C_PRE,
        DCKD_C_ACT,
        DCKD_C_WR,
        DCKD_C_RD,
        DCKD_C_ZQCL,
        DCKD_C_ZQCS
    } dckd_op_type;

    typedef enum {
        DCKD_S_RUN,
        DCKD_S_APD,
        DCKD_S_PPD,
        DCKD_S_SREF
    } dckd_pwr_type;

    // decoded read, handed to the data path
    typedef struct packed {
        logic valid;
        logic [`DCKD_BA_W-1:0] bank;
        logic [`DCKD_ADDR_W-1:0] col;
        logic [`DCKD_COL_LO_W-1:0] start;
        logic auto_pre;
        logic chop;
    } dckd_read_type;

endpackage : dckd_pkg

// file: hdl/dckd_row_mem.sv
/*
 per-bank open-row store: one word per bank, registered read.
 assumes one writer; read data appear one clock after the address.
*/
`timescale 1ns/100ps
`include "dckd_consts.svh"

module dckd_row_mem #(
    parameter int DEPTH = `DCKD_BANKS,
    parameter int WIDTH = `DCKD_ROW_W
) (
    input wire logic i_clock,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_reg[i_raddr];
    end
endmodule : dckd_row_mem

// file: sim/dckd_decoder_checker.sv
/* port assertions of the command and clock-enable decoder.
 assumes a bind to dckd_decoder, one clock and a synchronous reset. */
`timescale 1ns/100ps
`include "dckd_consts.svh"
module dckd_decoder_checker (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire dckd_pkg::dckd_cmd_type i_cmd,
    input wire logic [`DCKD_BANKS-1:0] o_bank_open,
    input wire logic o_burst_busy,
    input wire dckd_pkg::dckd_read_type o_read,
    input wire logic o_power_down,
    input wire logic o_self_refresh,
    input wire logic o_zq_busy,
    input wire logic o_zq_load
);
    // ----------------
    // decode helpers
    // ----------------
    logic cke_q;
    logic run;
    logic [2:0] c;
    // history restarts low, so the first high edge is a rise, as in the design
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= i_cmd.cke;
        end
    end
    assign run = cke_q && i_cmd.cke && !i_cmd.cs_n;
    assign c = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    sequence pde_s;
        cke_q && !i_cmd.cke && (i_cmd.cs_n || c == 3'h7);
    endsequence
    sequence sre_s;
        cke_q && !i_cmd.cke && !i_cmd.cs_n && c == 3'h1 && o_bank_open == '0 && !o_burst_busy;
    endsequence
    sequence rd_s;
        run && c == 3'h5 && !o_burst_busy;
    endsequence
    // ----------------
    // assertions
    // ----------------
    read_decode_a: assert property (rd_s |=> o_read.valid && o_burst_busy
        && o_read.bank == $past(i_cmd.ba) && o_read.start == $past(i_cmd.addr[2:0])
        && o_read.auto_pre == $past(i_cmd.addr[10])) else $error("read not decoded");
    read_cause_a: assert property (o_read.valid |-> $past(run && c == 3'h5))
        else $error("read without command");
    zq_short_a: assert property (run && c == 3'h6 && !i_cmd.addr[10] && !o_zq_busy
        |-> ##[1:65] o_zq_load) else $error("short calibration late");
    pd_entry_a: assert property (pde_s |-> ##2 o_power_down)
        else $error("power-down not entered");
    lp_hold_a: assert property (!cke_q && !i_cmd.cke && (o_power_down || o_self_refresh)
        |=> o_power_down || o_self_refresh) else $error("low-power state left");
    lp_exit_a: assert property (!cke_q && i_cmd.cke
        |-> ##2 !o_power_down && !o_self_refresh) else $error("low-power state kept");
    sr_entry_a: assert property (sre_s |-> ##2 o_self_refresh)
        else $error("self refresh missed");
    act_open_a: assert property (run && c == 3'h3 |-> ##2 o_bank_open[$past(i_cmd.ba, 2)])
        else $error("row not opened");
endmodule : dckd_decoder_checker

bind dckd_decoder dckd_decoder_checker dckd_decoder_checker_i (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_cmd(i_cmd), .o_bank_open(o_bank_open), .o_burst_busy(o_burst_busy),
    .o_read(o_read), .o_power_down(o_power_down), .o_self_refresh(o_self_refresh),
    .o_zq_busy(o_zq_busy), .o_zq_load(o_zq_load));

// file: sim/dckd_ctrl_model.sv
/* controller-side model: presents one command per rising edge.
 assumes callers keep cke at one level for at least three edges. */
`timescale 1ns/100ps
module dckd_ctrl_model (
    input wire logic i_clock,
    output dckd_pkg::dckd_cmd_type o_cmd,
    output logic o_reset_n
);
    // reset pin stays released; the bench resets through the synchronous input
    initial begin
        o_cmd = '0;
        o_reset_n = 1'b1;
    end
    // on a deselect the bank and address lines show the inverse of their last value, never a stale copy
    task automatic send(input logic cke, input logic [3:0] c, input logic [2:0] ba,
        input logic [14:0] a);
        if (i_clock) begin
            @(negedge i_clock);
        end
        o_cmd <= {cke, c, c[3] ? ~o_cmd.ba : ba, c[3] ? ~o_cmd.addr : a};
        @(posedge i_clock);
    endtask : send
endmodule : dckd_ctrl_model

// file: sim/dram_cke_command_decoder_tb.sv
/* bench of the command decoder: scenario tasks judge the outputs.
 assumes the controller model drives i_cmd and i_reset_n. */
`timescale 1ns/100ps
module dram_cke_command_decoder_tb;
    localparam logic [3:0] NOP = 4'h7, DES = 4'hf, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
    localparam logic [3:0] RD = 4'h5, ZQ = 4'h6;
    logic i_clock, i_nrst, i_reset_n, i_odt, i_otf_en, i_bc4_fixed;
    logic [2:0] i_row_bank;
    dckd_pkg::dckd_cmd_type i_cmd;
    dckd_pkg::dckd_read_type o_read;
    logic [14:0] o_row;
    logic [7:0] o_bank_open;
    logic o_burst_busy, o_power_down, o_active_pd, o_self_refresh;
    logic o_refresh_pulse, o_zq_busy, o_zq_load, o_init_done;
    int fails = 0;
    int num_checks = 0;
    int k;
    int f;
    dckd_ctrl_model dckd_ctrl_model_i (.i_clock(i_clock), .o_cmd(i_cmd), .o_reset_n(i_reset_n));
    // short calibration counts keep the run brief
    dckd_decoder #(.ZQINIT_CYC(8), .ZQOPER_CYC(8)) dckd_decoder_i (.i_clock(i_clock),
        .i_nrst(i_nrst), .i_reset_n(i_reset_n), .i_cmd(i_cmd), .i_odt(i_odt),
        .i_otf_en(i_otf_en), .i_bc4_fixed(i_bc4_fixed), .i_row_bank(i_row_bank),
        .o_row(o_row), .o_bank_open(o_bank_open), .o_burst_busy(o_burst_busy),
        .o_read(o_read), .o_power_down(o_power_down), .o_active_pd(o_active_pd),
        .o_self_refresh(o_self_refresh), .o_refresh_pulse(o_refresh_pulse),
        .o_zq_busy(o_zq_busy), .o_zq_load(o_zq_load), .o_init_done(o_init_done));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic cke, input logic [3:0] c, input logic [2:0] ba = 3'h0,
        input logic [14:0] a = 15'h0);
        dckd_ctrl_model_i.send(cke, c, ba, a);
    endtask : op
    task automatic nops(input int n);
        repeat (n) op(1'b1, NOP);
    endtask : nops
    // counts calibration-done pulses over n idle edges, noting the first
    task automatic zq_wait(input int n);
        k = 0;
        f = 0;
        for (int i = 1; i <= n; i++) begin
            op(1'b1, NOP);
            #1;
            if (o_zq_load === 1'b1) begin
                k++;
                f = (f == 0) ? i : f;
            end
        end
    endtask : zq_wait
    task automatic t_zq;
        op(1'b1, ZQ, 3'h0, 15'h400);
        op(1'b1, NOP);
        #1 chk(o_zq_busy, 1'b1);
        op(1'b1, ZQ);
        zq_wait(40);
        chk(k, 1);
        chk(o_init_done, 1'b1);
        op(1'b1, ZQ, 3'h0, 15'h400);
        zq_wait(40);
        chk(k, 1);
        op(1'b1, ZQ);
        zq_wait(80);
        chk(k == 1 && f <= 64, 1'b1);
        $display("calibration test done");
    endtask : t_zq
    task automatic t_read;
        logic [14:0] a;
        logic ap;
        op(1'b1, ACT, 3'h5, 15'h2a5c);
        nops(3);
        #1 chk(o_row, 15'h2a5c);
        for (int i = 0; i < 4; i++) begin
            ap = i[1];
            a = {2'h0, i[0], 1'b0, ap, 7'h0, 3'(i + 3)};
            @(negedge i_clock);
            i_otf_en = i[1];
            i_bc4_fixed = i[0];
            op(1'b1, RD, 3'h5, a);
            #1 chk({o_read.valid, o_read.bank, o_read.col, o_read.start, o_read.auto_pre,
                o_read.chop}, {1'b1, 3'h5, a, 3'(i + 3), ap, i[1] ^ i[0]});
            op(1'b1, NOP);
            nops(8);
            #1 chk(o_bank_open[5], !ap);
            if (ap) op(1'b1, ACT, 3'h5, 15'h2a5c);
        end
        $display("read test done");
    endtask : t_read
    task automatic t_burst;
        op(1'b1, RD, 3'h5, 15'h1000);
        #1 chk({o_read.valid, o_burst_busy}, 2'h3);
        for (int j = 1; j <= 4; j++) begin
            op(1'b1, j == 1 ? DES : (j == 2 ? 4'hd : NOP));
            #1 chk({o_read.valid, o_burst_busy}, {1'b0, j < 4});
        end
        // burst over: a deselected read must still start nothing
        op(1'b1, 4'hd, 3'h5, 15'h1000);
        #1 chk(o_read.valid, 1'b0);
        $display("burst test done");
    endtask : t_burst
    task automatic pd_cycle(input logic act);
        nops(4);
        @(negedge i_clock);
        i_odt = ~i_odt;
        op(1'b0, NOP);
        op(1'b0, RD, 3'h5);
        op(1'b0, DES);
        #1 chk({o_power_down, o_active_pd, o_read.valid}, {1'b1, act, 1'b0});
        op(1'b1, NOP);
        nops(2);
        #1 chk(o_power_down, 1'b0);
    endtask : pd_cycle
    task automatic t_power;
        pd_cycle(1'b1);
        op(1'b1, PRE, 3'h0, 15'h400);
        nops(3);
        #1 chk(o_bank_open, 8'h0);
        pd_cycle(1'b0);
        nops(4);
        op(1'b0, REF);
        op(1'b0, NOP);
        op(1'b0, DES);
        #1 chk({o_self_refresh, o_refresh_pulse}, 2'h2);
        op(1'b1, DES);
        nops(2);
        #1 chk(o_self_refresh, 1'b0);
        op(1'b1, REF);
        #1 chk(o_refresh_pulse, 1'b1);
        op(1'b1, NOP);
        #1 chk(o_refresh_pulse, 1'b0);
        $display("power test done");
    endtask : t_power
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        i_nrst = 1'b0;
        i_odt = 1'b0;
        i_otf_en = 1'b0;
        i_bc4_fixed = 1'b0;
        i_row_bank = 3'h5;
        repeat (8) @(negedge i_clock);
        chk({o_bank_open, o_read.valid, o_power_down, o_zq_busy}, 32'h0);
        i_nrst = 1'b1;
        op(1'b1, NOP);
        nops(2);
        t_zq();
        t_read();
        t_burst();
        t_power();
        give_verdict();
    end
    // hang guard: the scenarios need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge i_clock);
        fails++;
        give_verdict();
    end
endmodule : dram_cke_command_decoder_tb
